// *** common/dap_pkg.sv ***
// Constants for the two-axis positioner discrete I/O front end
package dap_pkg;
    // ******************************
    // Clock and input filter
    // ******************************
    localparam int CLK_HZ      = 100_000_000;
    localparam int FILT_MS     = 6;
    localparam int FILT_CYC_DF = (CLK_HZ / 1000) * FILT_MS;
    localparam int CNT_W       = 20;
    // ******************************
    // Raw input vector layout
    // ******************************
    localparam int N_POS   = 13;
    localparam int IX_RES  = 13;
    localparam int IX_AX   = 14;
    localparam int AX_STR  = 5;
    localparam int OF_GO   = 0;
    localparam int OF_HOME = 1;
    localparam int OF_EN   = 2;
    localparam int OF_HOLD = 3;
    localparam int OF_ABRT = 4;
    localparam int N_IN    = 24;
    // ******************************
    // Register map (byte addresses)
    // ******************************
    localparam logic [7:0] ADR_CFG  = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_INP  = 8'h08;
    localparam logic [7:0] MODE_IND = 8'h03;
    localparam logic [7:0] RST_MODE = 8'h03;
    localparam logic       RST_FMT  = 1'b0;
    localparam logic [3:0] RST_ALOC = 4'h7;
    localparam logic [3:0] BIN_MAX  = 4'hc;
    localparam logic [3:0] BCD_MAX  = 4'h2;
    localparam int         FMT_BIT  = 8;
    localparam int         ALOC_LSB = 16;
endpackage : dap_pkg

// *** src/dap_io.sv ***
// Discrete I/O front end of the two-axis positioner, independent mode
`timescale 1ns/1ps
// Summary of operation
// R1 - Error-reset rising edge clears present alarms
// R2 - Start rising edge begins move per axis
// R3 - Home rising edge begins home return
// R4 - Servo energised while drive-enable input ON
// R5 - Hold input OFF decelerates axis to stop
// R6 - Abort input turning ON discards remaining travel
// R7 - Controller keeps hold and abort normally ON
// R8 - Fault output ON when healthy, OFF on alarm
// R9 - Ready output after initialisation completes
// R10 - In-position output once target band reached
// R11 - Origin-done low at power-up, set after home
// R12 - Drive status output follows actual servo state
// R13 - Independent two-axis operation when mode is 3
// R14 - Format zero binary, nonzero BCD, default zero; only bit 8 of the format byte is kept
// R15 - Axis 1 takes low position bits, axis 2 rest; in BCD the top position bit is dropped
// R16 - Axis-1 allocation 1-12 bits or 1-2 digits
// R17 - Allocation unit bits in binary, digits BCD
// R18 - Each binary field read as unsigned number
// R19 - New input level recognised after 6 ms stable
// R20 - Commands ignored silently while servo input OFF
// R21 - BCD groups of four, units digit lowest
// R22 - Start before any home raises home error
// R23 - Filter is per-input counter from clock rate
module dap_io
    import dap_pkg::*;
#(
    parameter int FILT_CYC = FILT_CYC_DF
)(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    // Avalon-MM slave
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Controller inputs
    input  wire logic [12:0] i_pos_sel,
    input  wire logic        i_fault_clear_in,
    input  wire logic        i_axis1_go,
    input  wire logic        i_axis2_go,
    input  wire logic        i_axis1_origin_seek,
    input  wire logic        i_axis2_origin_seek,
    input  wire logic        i_axis1_drive_enable,
    input  wire logic        i_axis2_drive_enable,
    input  wire logic        i_axis1_hold_n,
    input  wire logic        i_axis2_hold_n,
    input  wire logic        i_axis1_abort_n,
    input  wire logic        i_axis2_abort_n,
    // Controller outputs
    output logic             o_fault_n,
    output logic             o_ready,
    output logic             o_axis1_in_position,
    output logic             o_axis2_in_position,
    output logic             o_axis1_origin_done,
    output logic             o_axis2_origin_done,
    output logic             o_axis1_drive_on_status,
    output logic             o_axis2_drive_on_status,
    // Motion core status
    input  wire logic        i_core_init_done,
    input  wire logic        i_core_alarm,
    input  wire logic [1:0]  i_core_in_pos,
    input  wire logic [1:0]  i_core_home_done,
    input  wire logic [1:0]  i_core_servo_on,
    // Motion core commands
    output logic [1:0]       o_core_start,
    output logic [1:0]       o_core_home,
    output logic [1:0]       o_core_servo_en,
    output logic [1:0]       o_core_hold,
    output logic [1:0]       o_core_abort,
    output logic             o_core_fault_clr,
    output logic [11:0]      o_core_pos1,
    output logic [11:0]      o_core_pos2
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    // ******************************
    // Input filter
    // ******************************
    logic [N_IN-1:0]  raw;
    logic [N_IN-1:0]  flt_reg;
    logic [N_IN-1:0]  flt_d_reg;
    logic [N_IN-1:0]  rise;
    logic [CNT_W-1:0] cnt_reg [N_IN];

    assign raw = {i_axis2_abort_n, i_axis2_hold_n, i_axis2_drive_enable,
                  i_axis2_origin_seek, i_axis2_go,
                  i_axis1_abort_n, i_axis1_hold_n, i_axis1_drive_enable,
                  i_axis1_origin_seek, i_axis1_go,
                  i_fault_clear_in, i_pos_sel};
    assign rise = flt_reg & ~flt_d_reg;

    for (genvar i = 0; i < N_IN; i++)
    begin : g_flt
        always_ff @(posedge i_clk or negedge i_arst_n)
        begin
            if (!i_arst_n)
            begin
                cnt_reg[i] <= '0;
                flt_reg[i] <= 1'b0;
            end
            else if (raw[i] == flt_reg[i])
                cnt_reg[i] <= '0; // R23
            else if (cnt_reg[i] == CNT_W'(FILT_CYC - 1))
            begin
                flt_reg[i] <= raw[i]; // R19
                cnt_reg[i] <= '0;
            end
            else
                cnt_reg[i] <= cnt_reg[i] + 1'b1; // R23
        end
        a_filter_hold: assert property ($changed(flt_reg[i]) |-> // R19
            $past(cnt_reg[i]) == CNT_W'(FILT_CYC - 1))
            else $error("filtered input changed before stable time");
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            flt_d_reg <= '0;
        else
            flt_d_reg <= flt_reg;
    end

    // ******************************
    // Configuration registers
    // ******************************
    logic [7:0]  mode_reg;
    logic        fmt_reg;
    logic [3:0]  aloc_reg;
    logic        herr_reg;
    logic        wait_reg;
    logic [31:0] rdata_reg;
    logic        req;
    logic        take;
    logic        wr_fmt;
    logic [3:0]  wr_aloc;
    logic        aloc_ok;

    assign req     = i_avs_read | i_avs_write;
    assign take    = req & ~wait_reg;
    assign wr_fmt  = i_avs_byteenable[1] ? i_avs_writedata[FMT_BIT]
                                         : fmt_reg;
    assign wr_aloc = i_avs_writedata[ALOC_LSB +: 4];
    // Out-of-range widths are refused, the old split stays in force
    assign aloc_ok = (wr_aloc != 4'h0) &&
                     (wr_aloc <= (wr_fmt ? BCD_MAX : BIN_MAX)); // R16

    // One wait state per access keeps read data registered
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            wait_reg <= 1'b1;
        else
            wait_reg <= ~(req & wait_reg);
    end
    a_avs_answer: assert property (req && wait_reg |=> !wait_reg)
        else $error("access not answered after one wait state");

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            mode_reg <= RST_MODE;
            fmt_reg  <= RST_FMT; // R14
            aloc_reg <= RST_ALOC;
        end
        else if (take && i_avs_write && i_avs_address == ADR_CFG)
        begin
            if (i_avs_byteenable[0])
                mode_reg <= i_avs_writedata[7:0];
            if (i_avs_byteenable[2] && aloc_ok)
            begin
                fmt_reg  <= wr_fmt;
                aloc_reg <= wr_aloc; // R17
            end
            else if (i_avs_byteenable[1] && wr_fmt == fmt_reg)
                fmt_reg  <= wr_fmt;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            rdata_reg <= '0;
        else if (i_avs_read && wait_reg)
        begin
            if (i_avs_address == ADR_CFG)
                rdata_reg <= {12'h000, aloc_reg, 7'h00, fmt_reg,
                              mode_reg};
            else if (i_avs_address == ADR_STAT)
                rdata_reg <= {21'h0, i_core_servo_on, 2'b00,
                              o_axis2_origin_done, o_axis1_origin_done,
                              o_axis2_in_position, o_axis1_in_position,
                              herr_reg, ~o_fault_n, o_ready};
            else if (i_avs_address == ADR_INP)
                rdata_reg <= {8'h00, flt_reg};
            else
                rdata_reg <= '0;
        end
    end

    assign o_avs_readdata    = rdata_reg;
    assign o_avs_waitrequest = wait_reg;

    // ******************************
    // Position number split
    // ******************************
    function automatic logic [11:0] bcd2(input logic [7:0] f);
        bcd2 = 12'(f[3:0]) + 12'(f[7:4]) * 12'h00a; // R21
    endfunction : bcd2

    logic [3:0]  nbits;
    logic [12:0] pos;
    logic [12:0] hi;
    logic [12:0] mask1;
    logic [11:0] p1;
    logic [11:0] p2;

    assign pos   = flt_reg[N_POS-1:0];
    assign nbits = fmt_reg ? {aloc_reg[1:0], 2'b00} : aloc_reg; // R17
    assign hi    = pos >> nbits; // R15
    assign mask1 = (13'h0001 << nbits) - 13'h0001;

    always_comb
    begin
        if (!fmt_reg)
        begin
            p1 = 12'(pos & mask1); // R18
            p2 = hi[11:0]; // R18
        end
        else
        begin
            p1 = (aloc_reg == 4'h1) ? bcd2({4'h0, pos[3:0]})
                                    : bcd2(pos[7:0]); // R14
            // Top position bit has no digit of its own, so it is dropped
            p2 = (aloc_reg == 4'h1) ? bcd2(hi[7:0])
                                    : bcd2({4'h0, hi[3:0]}); // R21
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_core_pos1 <= '0;
            o_core_pos2 <= '0;
        end
        else
        begin
            o_core_pos1 <= p1;
            o_core_pos2 <= p2;
        end
    end

    // ******************************
    // Alarm, ready and error reset
    // ******************************
    logic       ind;
    logic       clr_evt;
    logic [1:0] go_ok;
    logic [1:0] no_home;

    assign ind     = (mode_reg == MODE_IND); // R13
    assign clr_evt = rise[IX_RES];

    // A new fault in the clearing cycle survives the clear
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            herr_reg         <= 1'b0;
            o_fault_n        <= 1'b1;
            o_core_fault_clr <= 1'b0;
        end
        else
        begin
            o_core_fault_clr <= clr_evt; // R1
            if (|no_home)
                herr_reg <= 1'b1; // R22
            else if (clr_evt)
                herr_reg <= 1'b0;
            if (i_core_alarm || |no_home)
                o_fault_n <= 1'b0; // R8
            else if (clr_evt)
                o_fault_n <= 1'b1; // R1
        end
    end
    a_fault_set: assert property (i_core_alarm |=> !o_fault_n) // R8
        else $error("alarm did not drop fault output");
    a_fault_clear: assert property (clr_evt && !i_core_alarm // R1
        && !(|no_home) |=> o_fault_n && !herr_reg)
        else $error("error reset did not clear alarm");

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_ready <= 1'b0;
        else
            o_ready <= i_core_init_done; // R9
    end
    a_ready_follow: assert property (o_ready == $past(i_core_init_done)) // R9
        else $error("ready output not tracking init");

    // ******************************
    // Per-axis command and status
    // ******************************
    logic [1:0] inpos_reg;
    logic [1:0] odone_reg;
    logic [1:0] svst_reg;

    for (genvar a = 0; a < 2; a++)
    begin : g_ax
        localparam int B = IX_AX + a * AX_STR;
        logic en;
        assign en = flt_reg[B + OF_EN];
        assign go_ok[a]   = ind & en & rise[B + OF_GO]; // R20
        assign no_home[a] = go_ok[a] & ~odone_reg[a]; // R22

        always_ff @(posedge i_clk or negedge i_arst_n)
        begin
            if (!i_arst_n)
            begin
                o_core_start[a]    <= 1'b0;
                o_core_home[a]     <= 1'b0;
                o_core_servo_en[a] <= 1'b0;
                o_core_hold[a]     <= 1'b1;
                o_core_abort[a]    <= 1'b0;
            end
            else
            begin
                o_core_start[a]    <= go_ok[a] & odone_reg[a]; // R2
                o_core_home[a]     <= ind & en &
                                      rise[B + OF_HOME]; // R3
                o_core_servo_en[a] <= en; // R4
                o_core_hold[a]     <= ~flt_reg[B + OF_HOLD]; // R5
                o_core_abort[a]    <= rise[B + OF_ABRT]; // R6
            end
        end

        always_ff @(posedge i_clk or negedge i_arst_n)
        begin
            if (!i_arst_n)
            begin
                inpos_reg[a] <= 1'b0;
                odone_reg[a] <= 1'b0;
                svst_reg[a]  <= 1'b0;
            end
            else
            begin
                inpos_reg[a] <= i_core_in_pos[a]; // R10
                svst_reg[a]  <= i_core_servo_on[a]; // R12
                if (i_core_home_done[a])
                    odone_reg[a] <= 1'b1; // R11
                else if (o_core_home[a])
                    odone_reg[a] <= 1'b0;
            end
        end

        a_start_gate: assert property (o_core_start[a] |-> // R2
            $past(en) && $past(odone_reg[a]) && $past(ind))
            else $error("start issued while not allowed");
        a_home_gate: assert property (ind && rise[B + OF_HOME] // R20
            && !en |=> !o_core_home[a])
            else $error("home issued with servo input off");
        a_hold_stop: assert property ($fell(flt_reg[B + OF_HOLD]) // R5
            |=> o_core_hold[a])
            else $error("hold input did not stop axis");
        a_origin_clear: assert property (o_core_home[a] // R11
            && !i_core_home_done[a] |=> !odone_reg[a])
            else $error("origin done not cleared on home start");
        a_homeless_err: assert property (no_home[a] // R22
            |=> herr_reg && !o_fault_n && !o_core_start[a])
            else $error("start before home not flagged");
    end

    assign o_axis1_in_position     = inpos_reg[0];
    assign o_axis2_in_position     = inpos_reg[1];
    assign o_axis1_origin_done     = odone_reg[0];
    assign o_axis2_origin_done     = odone_reg[1];
    assign o_axis1_drive_on_status = svst_reg[0];
    assign o_axis2_drive_on_status = svst_reg[1];
endmodule : dap_io

// *** sim/dap_core_model.sv ***
// Behavioural motion core answering the discrete I/O front end
`timescale 1ns/1ps
module dap_core_model #(
    parameter int DLY = 6
)(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    // Commands from the front end
    input  wire logic [1:0] i_start,
    input  wire logic [1:0] i_home,
    input  wire logic [1:0] i_servo_en,
    // Status to the front end
    output logic            o_init_done,
    output logic [1:0]      o_in_pos,
    output logic [1:0]      o_home_done,
    output logic [1:0]      o_servo_on
);
    logic [7:0] init_reg;
    logic [7:0] home_reg [2];
    logic [7:0] move_reg [2];

    // ************
    // Axis motion
    // ************
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            init_reg    <= 8'h00;
            o_init_done <= 1'b0;
            o_servo_on  <= 2'h0;
            o_in_pos    <= 2'h0;
            o_home_done <= 2'h0;
            home_reg    <= '{8'h00, 8'h00};
            move_reg    <= '{8'h00, 8'h00};
        end
        else
        begin
            // Settles some time after reset, like a real boot
            if (init_reg != 8'h14)
                init_reg <= init_reg + 8'h01;
            else
                o_init_done <= 1'b1;
            o_servo_on <= i_servo_en;
            for (int a = 0; a < 2; a++)
            begin
                if (i_home[a])
                    home_reg[a] <= 8'(DLY);
                else if (home_reg[a] != 8'h00)
                    home_reg[a] <= home_reg[a] - 8'h01;
                o_home_done[a] <= (home_reg[a] == 8'h01);
                if (i_start[a])
                begin
                    move_reg[a] <= 8'(DLY);
                    o_in_pos[a] <= 1'b0;
                end
                else if (move_reg[a] != 8'h00)
                begin
                    move_reg[a] <= move_reg[a] - 8'h01;
                    o_in_pos[a] <= (move_reg[a] == 8'h01);
                end
            end
        end
    end
endmodule : dap_core_model

// *** sim/dap_io_test.sv ***
// Self-checking bench for the two-axis positioner I/O front end
`timescale 1ns/1ps
module dap_io_test;
    localparam int FC = 8;
    logic        i_clk = 1'b0;
    logic        i_arst_n = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0]  be = 4'h0;
    logic [12:0] pos_in = 13'h0;
    logic        clr = 1'b0;
    logic        alarm = 1'b0;
    logic [1:0]  go = 2'h0;
    logic [1:0]  home = 2'h0;
    logic [1:0]  en = 2'h0;
    logic [1:0]  hold_n = 2'h3;
    logic [1:0]  abort_n = 2'h3;
    logic [31:0] rdata, q;
    logic        wait_req, fault_n, ready, init_done, c_clr;
    logic [1:0]  in_pos, home_done, servo_on;
    logic [1:0]  c_start, c_home, c_en, c_hold, c_abort;
    logic [11:0] pos1, pos2;
    wire  [1:0]  in_p, org, son;
    logic [7:0]  n_start [2] = '{8'h00, 8'h00};
    logic [7:0]  n_home [2] = '{8'h00, 8'h00};
    logic [7:0]  n_abort [2] = '{8'h00, 8'h00};
    logic [7:0]  n_clr = 8'h00;
    int          n_fail = 0;
    int          n_compared = 0;

    always #5 i_clk = ~i_clk;

    dap_io #(.FILT_CYC(FC)) dut (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_req), .i_pos_sel(pos_in),
        .i_fault_clear_in(clr), .i_axis1_go(go[0]), .i_axis2_go(go[1]),
        .i_axis1_origin_seek(home[0]), .i_axis2_origin_seek(home[1]),
        .i_axis1_drive_enable(en[0]), .i_axis2_drive_enable(en[1]),
        .i_axis1_hold_n(hold_n[0]), .i_axis2_hold_n(hold_n[1]),
        .i_axis1_abort_n(abort_n[0]), .i_axis2_abort_n(abort_n[1]),
        .o_fault_n(fault_n), .o_ready(ready),
        .o_axis1_in_position(in_p[0]), .o_axis2_in_position(in_p[1]),
        .o_axis1_origin_done(org[0]), .o_axis2_origin_done(org[1]),
        .o_axis1_drive_on_status(son[0]), .o_axis2_drive_on_status(son[1]),
        .i_core_init_done(init_done), .i_core_alarm(alarm),
        .i_core_in_pos(in_pos), .i_core_home_done(home_done),
        .i_core_servo_on(servo_on), .o_core_start(c_start),
        .o_core_home(c_home), .o_core_servo_en(c_en), .o_core_hold(c_hold),
        .o_core_abort(c_abort), .o_core_fault_clr(c_clr),
        .o_core_pos1(pos1), .o_core_pos2(pos2));

    dap_core_model core (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_start(c_start),
        .i_home(c_home), .i_servo_en(c_en), .o_init_done(init_done),
        .o_in_pos(in_pos), .o_home_done(home_done), .o_servo_on(servo_on));

    // Command pulses are one cycle wide, so count them as they pass
    always_ff @(posedge i_clk)
    begin
        for (int a = 0; a < 2; a++)
        begin
            if (c_start[a] === 1'b1) n_start[a] <= n_start[a] + 8'h01;
            if (c_home[a] === 1'b1) n_home[a] <= n_home[a] + 8'h01;
            if (c_abort[a] === 1'b1) n_abort[a] <= n_abort[a] + 8'h01;
        end
        if (c_clr === 1'b1) n_clr <= n_clr + 8'h01;
    end

    // ************
    // Tasks
    // ************
    task automatic test_done();
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] b);
        int n;
        @(posedge i_clk);
        adr <= a;
        rd <= ~w;
        wr <= w;
        wd <= d;
        be <= b;
        for (n = 0; n < 20; n++)
        begin
            @(posedge i_clk);
            if (wait_req === 1'b0) break;
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n == 20)
        begin
            n_fail++;
            $display("[ERR] waitrequest expected 0 seen 1");
            test_done();
        end
    endtask : bus

    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
    endtask : step

    // ************
    // Sequence
    // ************
    initial
    begin
        step(5);
        i_arst_n <= 1'b1;
        step(30);
        chk("fault_n", 32'h1, fault_n);
        chk("ready", 32'h1, ready);
        chk("origin_done", 32'h0, org);
        chk("core_hold", 32'h0, c_hold);
        chk("abort_cnt", 32'h0101, {n_abort[1], n_abort[0]});
        bus(1'b0, 8'h00, 32'h0, 4'hf);
        chk("cfg_reset", 32'h0007_0003, q);
        bus(1'b0, 8'h0c, 32'h0, 4'hf);
        chk("unmapped", 32'h0, q);
        for (int a = 0; a < 2; a++)
        begin
            go[a] <= 1'b1;
            step(30);
            chk("start_no_en", 32'h0, n_start[a]);
            chk("fault_no_en", 32'h1, fault_n);
            go[a] <= 1'b0;
            en[a] <= 1'b1;
            step(30);
            chk("servo_en", 32'h1, c_en[a]);
            chk("servo_status", 32'h1, son[a]);
            go[a] <= 1'b1;
            step(30);
            chk("start_unhomed", 32'h0, n_start[a]);
            chk("fault_unhomed", 32'h0, fault_n);
            bus(1'b0, 8'h04, 32'h0, 4'hf);
            chk("home_err", 32'h1, q[2]);
            chk("stat_servo", 32'h1, q[9 + a]);
            go[a] <= 1'b0;
            clr <= 1'b1;
            step(30);
            chk("clr_cnt", a + 1, n_clr);
            chk("fault_cleared", 32'h1, fault_n);
            clr <= 1'b0;
            home[a] <= 1'b1;
            step(FC / 2);
            home[a] <= 1'b0;
            step(30);
            chk("home_glitch", 32'h0, n_home[a]);
            home[a] <= 1'b1;
            step(30);
            chk("home_cnt", 32'h1, n_home[a]);
            chk("origin_set", 32'h1, org[a]);
            home[a] <= 1'b0;
            pos_in <= 13'h1a5b;
            step(30);
            go[a] <= 1'b1;
            step(30);
            chk("start_cnt", 32'h1, n_start[a]);
            chk("in_position", 32'h1, in_p[a]);
            go[a] <= 1'b0;
            hold_n[a] <= 1'b0;
            step(30);
            chk("hold", 32'h1, c_hold[a]);
            hold_n[a] <= 1'b1;
            abort_n[a] <= 1'b0;
            step(30);
            abort_n[a] <= 1'b1;
            step(30);
            chk("abort_cnt", 32'h2, n_abort[a]);
        end
        chk("pos1_bin", 32'h05b, pos1);
        chk("pos2_bin", 32'h034, pos2);
        bus(1'b1, 8'h00, 32'h0002_0103, 4'h7);
        bus(1'b0, 8'h00, 32'h0, 4'hf);
        chk("cfg_bcd", 32'h0002_0103, q);
        bus(1'b1, 8'h00, 32'h0003_0000, 4'h4);
        bus(1'b0, 8'h00, 32'h0, 4'hf);
        chk("alloc_refused", 32'h0002_0103, q);
        pos_in <= 13'h1974;
        step(30);
        chk("pos1_bcd", 32'h04a, pos1);
        chk("pos2_bcd", 32'h009, pos2);
        bus(1'b1, 8'h00, 32'h0001_0000, 4'h4);
        step(2);
        chk("pos1_bcd1", 32'h004, pos1);
        chk("pos2_bcd2", 32'h061, pos2);
        alarm <= 1'b1;
        step(1);
        alarm <= 1'b0;
        step(2);
        chk("alarm", 32'h0, fault_n);
        bus(1'b1, 8'h00, 32'h0000_0001, 4'h1);
        go[0] <= 1'b1;
        step(30);
        chk("start_mode", 32'h1, n_start[0]);
        test_done();
    end
endmodule : dap_io_test
